// *** test/pbs_bus_wire_model.sv ***
/*
 * master side model of the shared data and parity wires: resolves who drives them.
 * assumes the master raises masterDrive only while the port has its drivers off.
 */
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_bus_wire_model
    import pbs_pkg::*;
#(
    parameter int W = `PBS_DATA_W + `PBS_PAR_W
)(
    input  wire logic         ref_clk,
    input  wire logic         dataOutEnN,
    input  wire logic [W-1:0] portWord,
    input  wire logic         masterDrive,
    input  wire logic [W-1:0] masterWord,
    output logic      [W-1:0] wireWord
);
    // ==========================================================================
    // wire resolution
    // ==========================================================================
    logic [W-1:0] lastWord_r = '0;
    // released wires toggle instead of holding, so a stale value never reads back as data
    assign wireWord = !dataOutEnN ? portWord : (masterDrive ? masterWord : ~lastWord_r);
    always_ff @(posedge ref_clk) begin
        lastWord_r <= wireWord;
    end
endmodule : pbs_bus_wire_model

// *** test/pipelined_burst_sram_port_test.sv ***
/*
 * self-checking bench of the pipelined burst sram port: writes, bursts, selects, sleep.
 * assumes read data on dataOut two edges after the strobe is driven.
 */
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pipelined_burst_sram_port_test
    import pbs_pkg::*;
;
    // ==========================================================================
    // signals
    // ==========================================================================
    logic               ref_clk = 1'h0;
    logic               rstn, clkEn, outputEnableN, sleepReq, strap, masterDrive;
    pbs_ctrl_type       ctrl;
    logic [18:0]        address;
    logic [17:0]        masterWord, wireWord;
    logic [15:0]        dataOut;
    logic [1:0]         parOut;
    logic               dataOutEnN, selected, sleeping;
    int                 bad_count = 0, n_tests = 0, cycles = 0;
    localparam logic [18:0] BASE = 19'h1_2340;

    always #20 ref_clk = ~ref_clk;

    pbs_sram_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .ctrl(ctrl), .address(address),
        .outputEnableN(outputEnableN), .sleep_request(sleepReq), .burstOrderStrap(strap),
        .dataIn(wireWord[15:0]), .parity_data_lines_in(wireWord[17:16]), .dataOut(dataOut),
        .parity_data_lines_out(parOut), .dataOutEnN(dataOutEnN), .selected(selected), .sleeping(sleeping));
    pbs_bus_wire_model i_wire (.ref_clk(ref_clk), .dataOutEnN(dataOutEnN), .portWord({parOut, dataOut}),
        .masterDrive(masterDrive), .masterWord(masterWord), .wireWord(wireWord));

    // ==========================================================================
    // shared tasks
    // ==========================================================================
    function automatic logic [17:0] word(input int k);
        return {2'(k), 16'hA500 + 16'(k)};
    endfunction : word
    task automatic step();
        @(posedge ref_clk);
        #2;
    endtask : step
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic idle();
        ctrl = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 2'h3};
        masterDrive = 1'h0;
    endtask : idle
    task automatic do_reset(input logic s);
        rstn = 1'h0;
        strap = s;
        repeat (8) @(posedge ref_clk);
        #2 rstn = 1'h1;
    endtask : do_reset
    // byte lanes stay off: the all-bytes write alone must store the whole word
    task automatic wr(input logic [18:0] a, input logic [17:0] w, input logic both);
        ctrl.controllerAddressStrobeN = 1'h0;
        ctrl.processorAddressStrobeN = !both;
        ctrl.allBytesWriteN = 1'h0;
        address = a;
        masterWord = w;
        masterDrive = 1'h1;
        outputEnableN = 1'h1;
        step();
        idle();
    endtask : wr
    task automatic read_burst(input logic [1:0] start, input int n, input logic ilv);
        logic [1:0] idx;
        logic [17:0] expWord;
        ctrl.controllerAddressStrobeN = 1'h0;
        ctrl.chipSelectPrimaryN = 1'h1;
        step();
        idle();
        repeat (2) step();
        chk("selected after deselect", selected, 1'h0);
        outputEnableN = 1'h0;
        address = BASE | start;
        ctrl.processorAddressStrobeN = 1'h0;
        step();
        ctrl.processorAddressStrobeN = 1'h1;
        ctrl.burstAdvanceN = !(n > 1);
        step();
        chk("first read clock masked", dataOutEnN, 1'h1);
        for (int i = 0; i < n; i++) begin
            step();
            idx = ilv ? (start ^ 2'(i)) : (start + 2'(i));
            expWord = word(idx);
            chk("burst data", dataOut, expWord[15:0]);
            chk("burst parity", parOut, expWord[17:16]);
            if (i < 2) chk("output drive", dataOutEnN, 1'h0);
            if (i == 2) begin
                outputEnableN = 1'h1;
                #1 chk("output enable async", dataOutEnN, 1'h1);
                outputEnableN = 1'h0;
            end
        end
        idle();
        outputEnableN = 1'h1;
    endtask : read_burst

    // ==========================================================================
    // scenarios
    // ==========================================================================
    task automatic test_write_burst(input logic ilv);
        for (int k = 0; k < 4; k++) wr(BASE + 19'(k), word(k), 1'h0);
        step();
        read_burst(2'h1, 4, ilv);
    endtask : test_write_burst
    task automatic test_strobe_rules();
        wr(BASE + 19'h0_0002, 18'h3_FFFF, 1'h1);
        ctrl.processorAddressStrobeN = 1'h0;
        ctrl.chipSelectPrimaryN = 1'h1;
        step();
        idle();
        repeat (2) step();
        chk("ignored processor strobe", selected, 1'h1);
        read_burst(2'h2, 1, 1'h0);
    endtask : test_strobe_rules
    task automatic test_select_combos();
        for (int c = 0; c < 8; c++) begin
            {ctrl.chipSelectPrimaryN, ctrl.chipSelectExpandHigh, ctrl.chipSelectExpandN} = 3'(c);
            ctrl.controllerAddressStrobeN = 1'h0;
            address = BASE;
            step();
            idle();
            repeat (2) step();
            chk("select combination", selected, c == 2);
        end
    endtask : test_select_combos
    // lane 1 alone is written over a cleared word; lane 0 must keep its zeros
    task automatic test_byte_write();
        wr(BASE + 19'h0_0004, 18'h0_0000, 1'h0);
        ctrl.controllerAddressStrobeN = 1'h0;
        ctrl.byteWriteQualifierN = 1'h0;
        ctrl.byteLaneSelectN = 2'h1;
        address = BASE + 19'h0_0004;
        masterWord = 18'h3_FFFF;
        masterDrive = 1'h1;
        step();
        idle();
        ctrl.controllerAddressStrobeN = 1'h0;
        step();
        idle();
        step();
        chk("byte lane data", dataOut, 16'hFF00);
        chk("byte lane parity", parOut, 2'h2);
    endtask : test_byte_write
    task automatic test_clock_hold();
        clkEn = 1'h0;
        ctrl.controllerAddressStrobeN = 1'h0;
        ctrl.chipSelectPrimaryN = 1'h1;
        repeat (3) step();
        chk("frozen by clock enable", selected, 1'h1);
        clkEn = 1'h1;
        repeat (2) step();
        chk("deselect once enabled", selected, 1'h0);
        idle();
    endtask : test_clock_hold
    task automatic test_sleep();
        sleepReq = 1'h1;
        repeat (2) step();
        chk("sleeping", sleeping, 1'h1);
        wr(BASE, 18'h0_1234, 1'h0);
        sleepReq = 1'h0;
        repeat (2) step();
        chk("awake", sleeping, 1'h0);
        read_burst(2'h0, 1, 1'h0);
    endtask : test_sleep

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        rstn = 1'h0;
        clkEn = 1'h1;
        outputEnableN = 1'h1;
        sleepReq = 1'h0;
        strap = 1'h0;
        address = '0;
        masterWord = '0;
        idle();
        do_reset(1'h0);
        test_write_burst(1'h0);
        test_strobe_rules();
        test_byte_write();
        test_clock_hold();
        test_select_combos();
        test_sleep();
        do_reset(1'h1);
        read_burst(2'h1, 4, 1'h1);
        tally_and_finish();
    end
endmodule : pipelined_burst_sram_port_test

// *** verilog/pbs_burst_counter.sv ***
/*
 * two-bit wraparound burst counter with linear or interleaved order.
 * assumes the parent decides load and advance on the same clock edge.
 */
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_burst_counter
    import pbs_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic                    clkEn,
    input  wire logic                    interleave,
    input  wire logic                    load,
    input  wire logic [`PBS_BURST_W-1:0] loadValue,
    input  wire logic                    advance,
    output logic      [`PBS_BURST_W-1:0] burstAddr
);
    // ==========================================================================
    // sequencing
    // ==========================================================================
    logic [`PBS_BURST_W-1:0] start_r;
    logic [`PBS_BURST_W-1:0] step_r;
    logic [`PBS_BURST_W-1:0] stepInc;

    assign stepInc   = step_r + 2'h1;
    // interleaved order xors the step into the start, linear adds it; both wrap in four
    assign burstAddr = interleave ? (start_r ^ step_r) : (start_r + step_r);   // [R15]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_r <= `PBS_BURST_RST;
            step_r  <= `PBS_BURST_RST;
        end else if (clkEn) begin
            if (load) begin                                                 // [R5] [R6]
                start_r <= loadValue;
                step_r  <= `PBS_BURST_RST;
            end else if (advance) begin                                     // [R2]
                step_r  <= stepInc;
            end
        end
    end
endmodule : pbs_burst_counter

// *** verilog/pbs_defines.svh ***
/*
 * shared timing-free constants for the pipelined burst sram port: widths and encodings.
 * assumes inclusion from the package and from the design modules by bare name.
 */
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// ==========================================================================
// sizes
// ==========================================================================
`define PBS_ADDR_W      19
`define PBS_DATA_W      16
`define PBS_PAR_W       2
`define PBS_BURST_W     2
// ==========================================================================
// reset values
// ==========================================================================
`define PBS_BURST_RST   2'h0
`define PBS_ORDER_LIN   1'b0

`endif

// *** verilog/pbs_pkg.sv ***
/*
 * types of the pipelined burst sram port.
 * assumes pbs_defines.svh is on the include path.
 */
`include "pbs_defines.svh"
package pbs_pkg;
    typedef enum logic [1:0] {
        PBS_DESEL  = 2'b00,
        PBS_READ   = 2'b01,
        PBS_WRITE  = 2'b10,
        PBS_SLEEP  = 2'b11
    } pbs_state_type;

    typedef struct packed {
        logic                       chipSelectPrimaryN;
        logic                       chipSelectExpandHigh;
        logic                       chipSelectExpandN;
        logic                       processorAddressStrobeN;
        logic                       controllerAddressStrobeN;
        logic                       burstAdvanceN;
        logic                       allBytesWriteN;
        logic                       byteWriteQualifierN;
        logic [`PBS_PAR_W-1:0]      byteLaneSelectN;
    } pbs_ctrl_type;
endpackage : pbs_pkg

// *** verilog/pbs_sram_port.sv ***
/*
 * synchronous control port of a pipelined burst sram with its array.
 * assumes a bus master synchronous to ref_clk; the bench resolves the data wires from dataOutEnN.
 */
// Operation
// [R1]: every synchronous input is sampled only on the rising edge of ref_clk.
// [R2]: in a burst the counter steps on each edge where burst advance is low.
// [R3]: the part is selected only with primary select low, expand-high high and expand-low low.
// [R4]: a processor strobe is ignored while the primary select is high.
// [R5]: a taken processor strobe captures the address and loads its two low bits into the counter.
// [R6]: a controller strobe captures the address and loads its two low bits into the counter.
// [R7]: with both strobes low only the processor strobe acts.
// [R8]: output enable low drives data and parity, high floats them as inputs, asynchronously.
// [R9]: on the first read clock after deselect the outputs stay disabled whatever output enable says.
// [R10]: write data is registered from the data lines on the rising edge.
// [R11]: read data appears one registered stage after its address.
// [R12]: sleep high puts the part in a quiet state keeping its contents.
// [R13]: the burst order strap picks linear when low and interleaved when high.
// [R14]: all-bytes write low writes every byte regardless of byte controls.
// [R15]: the burst counter wraps within four following the chosen order.
// [R16]: while deselected no access starts and no read data is driven.
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_sram_port
    import pbs_pkg::*;
#(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int DATA_W = `PBS_DATA_W,
    parameter int PAR_W  = `PBS_PAR_W
)(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                clkEn,
    input  wire pbs_ctrl_type        ctrl,
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                outputEnableN,
    input  wire logic                sleep_request,
    input  wire logic                burstOrderStrap,
    input  wire logic [DATA_W-1:0]   dataIn,
    input  wire logic [PAR_W-1:0]    parity_data_lines_in,
    output logic      [DATA_W-1:0]   dataOut,
    output logic      [PAR_W-1:0]    parity_data_lines_out,
    output logic                     dataOutEnN,
    output logic                     selected,
    output logic                     sleeping
);
    localparam int LANE_W = DATA_W / PAR_W;

    // ==========================================================================
    // input registers
    // ==========================================================================
    pbs_ctrl_type              ctrl_r;
    logic [ADDR_W-1:0]         addrIn_r;
    logic [DATA_W-1:0]         wrData_r;
    logic [PAR_W-1:0]          wrPar_r;
    logic [ADDR_W-1:0]         addr_r;
    logic                      write_r;
    logic                      interleave_r;
    logic                      strapSeen_r;
    pbs_state_type             state_r;
    pbs_state_type             state_nxt;
    logic                      firstRead_r;
    logic [DATA_W-1:0]         rdData_r;
    logic [PAR_W-1:0]          rdPar_r;
    logic                      active;

    // clock edge freezes everything while asleep except the sleep tracking and strap capture
    assign active = clkEn && !sleep_request;                                 // [R12]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r   <= '1;
            addrIn_r <= '0;
            wrData_r <= '0;
            wrPar_r  <= '0;
        end else if (active) begin                                          // [R1]
            ctrl_r   <= ctrl;
            addrIn_r <= address;
            wrData_r <= dataIn;                                             // [R10]
            wrPar_r  <= parity_data_lines_in;
        end
    end

    // ==========================================================================
    // decode of the sampled controls
    // ==========================================================================
    wire chipSel    = !ctrl_r.chipSelectPrimaryN && ctrl_r.chipSelectExpandHigh
                      && !ctrl_r.chipSelectExpandN;                         // [R3]
    wire procStrobe = !ctrl_r.processorAddressStrobeN && !ctrl_r.chipSelectPrimaryN; // [R4]
    wire procStart  = procStrobe && chipSel;
    // controller strobe only counts when the processor strobe did not act
    wire ctrlStrobe = !ctrl_r.controllerAddressStrobeN && !procStrobe;      // [R7]
    wire ctrlStart  = ctrlStrobe && chipSel;
    wire startCyc   = procStart || ctrlStart;
    wire deselCyc   = (procStrobe || !ctrl_r.controllerAddressStrobeN) && !chipSel; // [R16]
    wire byteWrite  = !ctrl_r.byteWriteQualifierN && !(&ctrl_r.byteLaneSelectN);
    // the processor-strobe cycle is always a read; write controls apply from the next edge
    wire isWrite    = !procStart && (!ctrl_r.allBytesWriteN || byteWrite);
    wire advance    = !startCyc && !ctrl_r.burstAdvanceN
                      && (state_r == PBS_READ || state_r == PBS_WRITE);     // [R2]

    logic [`PBS_BURST_W-1:0] burstAddr;

    pbs_burst_counter u_counter (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .clkEn      (active),
        .interleave (interleave_r),
        .load       (startCyc),
        .loadValue  (addrIn_r[`PBS_BURST_W-1:0]),
        .advance    (advance),
        .burstAddr  (burstAddr)
    );

    // ==========================================================================
    // access state
    // ==========================================================================
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PBS_SLEEP: state_nxt = PBS_DESEL;
            default: begin
                if (deselCyc)
                    state_nxt = PBS_DESEL;
                else if (startCyc)
                    state_nxt = isWrite ? PBS_WRITE : PBS_READ;
                else if (state_r != PBS_DESEL)
                    state_nxt = isWrite ? PBS_WRITE : PBS_READ;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r      <= PBS_DESEL;
            firstRead_r  <= 1'b0;
            interleave_r <= `PBS_ORDER_LIN;
            strapSeen_r  <= 1'b0;
            addr_r       <= '0;
        end else if (clkEn) begin
            if (!strapSeen_r) begin                                         // [R13]
                interleave_r <= burstOrderStrap;
                strapSeen_r  <= 1'b1;
            end
            if (sleep_request) begin
                state_r     <= PBS_SLEEP;
                firstRead_r <= 1'b0;
            end else begin
                state_r     <= state_nxt;
                firstRead_r <= (state_r == PBS_DESEL || state_r == PBS_SLEEP)
                               && state_nxt == PBS_READ;                    // [R9]
                if (startCyc)
                    addr_r <= addrIn_r;                                     // [R5] [R6]
            end
        end
    end

    // ==========================================================================
    // array and read pipeline
    // ==========================================================================
    wire [ADDR_W-1:0] curAddr = startCyc ? addrIn_r : {addr_r[ADDR_W-1:`PBS_BURST_W], burstAddr};
    wire              doWrite = active && !deselCyc && isWrite && (startCyc || state_r != PBS_DESEL);
    wire              doRead  = active && !deselCyc && !isWrite && (startCyc || state_r != PBS_DESEL);

    wire [DATA_W-1:0] rdWord;
    wire [PAR_W-1:0]  rdParWord;

    // each lane is one data byte plus its parity bit, in an array of its own
    // so that no two processes ever write the same memory variable
    genvar gl;
    generate
        for (gl = 0; gl < PAR_W; gl++) begin : g_lane
            logic [LANE_W:0] laneMem [0:(1<<ADDR_W)-1];
            wire laneWr = !ctrl_r.allBytesWriteN
                          || (!ctrl_r.byteWriteQualifierN && !ctrl_r.byteLaneSelectN[gl]); // [R14]
            always_ff @(posedge ref_clk) begin
                if (doWrite && laneWr) begin
                    laneMem[curAddr] <= {wrPar_r[gl], wrData_r[gl*LANE_W +: LANE_W]};
                end
            end
            assign rdWord[gl*LANE_W +: LANE_W] = laneMem[curAddr][LANE_W-1:0];
            assign rdParWord[gl]               = laneMem[curAddr][LANE_W];
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_r <= '0;
            rdPar_r  <= '0;
        end else if (doRead) begin                                          // [R11]
            rdData_r <= rdWord;
            rdPar_r  <= rdParWord;
        end
    end

    assign dataOut               = rdData_r;
    assign parity_data_lines_out = rdPar_r;
    // output enable is combinational so it acts without the clock
    assign dataOutEnN = outputEnableN || firstRead_r
                        || state_r != PBS_READ;                             // [R8] [R16]
    assign selected   = state_r == PBS_READ || state_r == PBS_WRITE;
    assign sleeping   = state_r == PBS_SLEEP;

    // ==========================================================================
    // checks
    // ==========================================================================
    AST_DESEL_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn)   // [R16]
        state_r == PBS_DESEL |-> dataOutEnN)
        else $error("data driven while deselected");
    AST_OE_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rstn)    // [R8]
        outputEnableN |-> dataOutEnN)
        else $error("data driven with output enable high");
    AST_FIRST_MASK: assert property (@(posedge ref_clk) disable iff (!rstn)    // [R9]
        (clkEn && !sleep_request && state_r == PBS_DESEL && state_nxt == PBS_READ) |=> dataOutEnN)
        else $error("first read clock not masked");
    AST_PROC_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)     // [R7]
        (active && procStart) |=> addr_r == $past(addrIn_r))
        else $error("processor strobe did not load address");
    AST_PROC_IGNORED: assert property (@(posedge ref_clk) disable iff (!rstn)  // [R4]
        (active && ctrl_r.chipSelectPrimaryN && ctrl_r.controllerAddressStrobeN && selected) |=> selected)
        else $error("processor strobe taken with primary select high");
    AST_SLEEP_STATE: assert property (@(posedge ref_clk) disable iff (!rstn)   // [R12]
        (clkEn && sleep_request) |=> sleeping && dataOutEnN)
        else $error("sleep not entered");
    AST_SELECT_DECODE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R3]
        (active && startCyc) |-> (!ctrl_r.chipSelectPrimaryN && ctrl_r.chipSelectExpandHigh
                                  && !ctrl_r.chipSelectExpandN))
        else $error("access started without full select");
    AST_LOAD_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)      // [R5]
        (active && startCyc) |=> burstAddr == $past(addrIn_r[`PBS_BURST_W-1:0]))
        else $error("burst counter not loaded");
endmodule : pbs_sram_port
